// ---- tb/test_cpu_inc_dec_skip_or_branch.sv ----
// self-checking bench for the inc/dec-skip, or and absolute-branch core
// assumes cidsb_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none

module test_cpu_inc_dec_skip_or_branch;
  import cidsb_pkg::*;

  // ----------------------------------------------------------------
  // ports, reference state and counters
  // ----------------------------------------------------------------
  logic        mclk_in               = 1'b0;
  logic        nrst_in               = 1'b0;
  logic        ce_in                 = 1'b0;
  logic        instr_valid_in        = 1'b0;
  logic [13:0] instr_in              = 14'h0000;
  logic [6:0]  pc_high_latch_in      = 7'h00;
  logic [6:0]  peek_addr_in          = 7'h00;
  logic [7:0]  acc_out;
  logic [7:0]  peek_data_out;
  logic        zero_flag_out;
  logic        no_operation_next_out;
  logic [14:0] pc_out;
  int          n_fail                = 0;
  int          check_count           = 0;
  logic [7:0]  m_acc;
  logic [7:0]  m_mem [128];
  logic [14:0] m_pc;
  logic        m_z;
  int          m_pend;

  always #12.5 mclk_in = ~mclk_in;

  cidsb_core i_cidsb_core (
    .mclk_in               (mclk_in),
    .nrst_in               (nrst_in),
    .ce_in                 (ce_in),
    .instr_valid_in        (instr_valid_in),
    .instr_in              (instr_in),
    .pc_high_latch_in      (pc_high_latch_in),
    .peek_addr_in          (peek_addr_in),
    .acc_out               (acc_out),
    .zero_flag_out         (zero_flag_out),
    .pc_out                (pc_out),
    .no_operation_next_out (no_operation_next_out),
    .peek_data_out         (peek_data_out)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_all();
    chk(acc_out, m_acc, "acc");
    chk(zero_flag_out, m_z, "zero");
    chk(pc_out, m_pc, "pc");
    chk(no_operation_next_out, m_pend != 0, "skip");
    chk(peek_data_out, m_mem[peek_addr_in], "file");
  endtask

  // reference model for one taken word, run as the word goes onto the port
  task automatic model(input logic [13:0] w);
    logic [7:0] r;
    logic [6:0] f;
    f = w[6:0];
    if (m_pend != 0) begin
      if (m_pend == 1) m_pc = m_pc + 15'h0001;
      m_pend = 0;
    end else if (w[13:11] == CIDSB_OP_BRANCH_ABSOLUTE) begin
      m_pc = {pc_high_latch_in[6:3], w[10:0]};
      m_pend = 2;
    end else begin
      m_pc = m_pc + 15'h0001;
      case (w[13:8])
        CIDSB_OP_DECREMENT_SKIP_ZERO: r = m_mem[f] - 8'h01;
        CIDSB_OP_OR_ACC_WITH_REGISTER: r = m_acc | m_mem[f];
        CIDSB_OP_OR_LITERAL_INTO_ACC: r = m_acc | w[7:0];
        default: r = m_mem[f] + 8'h01;
      endcase
      if (w[13:8] == CIDSB_OP_OR_LITERAL_INTO_ACC) m_acc = r;
      else if (w[7]) m_mem[f] = r;
      else m_acc = r;
      if (w[13:8] inside {CIDSB_OP_INCREMENT_REGISTER, CIDSB_OP_OR_ACC_WITH_REGISTER, CIDSB_OP_OR_LITERAL_INTO_ACC})
        m_z = (r == 8'h00);
      else if (r == 8'h00) m_pend = 1;
    end
  endtask

  // valid stays high between words, so consecutive offers land on consecutive edges
  task automatic offer(input logic [13:0] w);
    @(posedge mclk_in);
    instr_in <= w;
    instr_valid_in <= 1'b1;
    peek_addr_in <= w[6:0];
    model(w);
  endtask

  // the idle cycle after the last word lets the peek port show the written value
  task automatic settle();
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    check_all();
  endtask

  task automatic exec(input logic [13:0] w);
    offer(w);
    settle();
  endtask

  task automatic do_reset();
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    ce_in <= 1'b1;
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    m_acc = 8'h00;
    m_z = 1'b0;
    m_pc = 15'h0000;
    m_pend = 0;
    foreach (m_mem[i]) m_mem[i] = 8'h00;
    #1;
    check_all();
    $display("test reset done");
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_or_literal();
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h00});
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h5A});
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'hA5});
    $display("test or_literal done");
  endtask

  task automatic t_increment();
    exec({CIDSB_OP_INCREMENT_REGISTER, 1'b1, 7'h7F});
    exec({CIDSB_OP_INCREMENT_REGISTER, 1'b1, 7'h7F});
    exec({CIDSB_OP_INCREMENT_REGISTER, 1'b0, 7'h7F});
    $display("test increment done");
  endtask

  task automatic t_or_register();
    exec({CIDSB_OP_OR_ACC_WITH_REGISTER, 1'b1, 7'h01});
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h80});
    exec({CIDSB_OP_OR_ACC_WITH_REGISTER, 1'b1, 7'h01});
    exec({CIDSB_OP_OR_ACC_WITH_REGISTER, 1'b0, 7'h01});
    $display("test or_register done");
  endtask

  task automatic t_dec_skip();
    exec({CIDSB_OP_INCREMENT_REGISTER, 1'b1, 7'h05});
    exec({CIDSB_OP_DECREMENT_SKIP_ZERO, 1'b1, 7'h05});
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h0F});
    exec({CIDSB_OP_DECREMENT_SKIP_ZERO, 1'b0, 7'h05});
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h00});
    $display("test dec_skip done");
  endtask

  task automatic t_inc_skip();
    exec({CIDSB_OP_DECREMENT_SKIP_ZERO, 1'b1, 7'h06});
    exec({CIDSB_OP_INCREMENT_SKIP_ZERO, 1'b0, 7'h06});
    exec({CIDSB_OP_INCREMENT_REGISTER, 1'b1, 7'h06});
    exec({CIDSB_OP_INCREMENT_REGISTER, 1'b0, 7'h06});
    exec({CIDSB_OP_INCREMENT_SKIP_ZERO, 1'b1, 7'h06});
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h01});
    $display("test inc_skip done");
  endtask

  task automatic t_branch();
    @(posedge mclk_in);
    pc_high_latch_in <= 7'h55;
    exec({CIDSB_OP_BRANCH_ABSOLUTE, 11'h7FF});
    exec({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h02});
    @(posedge mclk_in);
    pc_high_latch_in <= 7'h2A;
    exec({CIDSB_OP_BRANCH_ABSOLUTE, 11'h000});
    exec({CIDSB_OP_INCREMENT_REGISTER, 1'b1, 7'h00});
    $display("test branch done");
  endtask

  // words on consecutive edges reach the swallow slot on the very next edge, where exec always leaves two idle cycles before it
  task automatic t_back_to_back();
    offer({CIDSB_OP_INCREMENT_REGISTER, 1'b1, 7'h10});
    offer({CIDSB_OP_DECREMENT_SKIP_ZERO, 1'b1, 7'h10});
    offer({CIDSB_OP_INCREMENT_REGISTER, 1'b1, 7'h10});
    offer({CIDSB_OP_DECREMENT_SKIP_ZERO, 1'b1, 7'h10});
    offer({CIDSB_OP_INCREMENT_SKIP_ZERO, 1'b1, 7'h10});
    offer({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h40});
    offer({CIDSB_OP_BRANCH_ABSOLUTE, 11'h123});
    offer({CIDSB_OP_OR_LITERAL_INTO_ACC, 8'h10});
    settle();
    $display("test back_to_back done");
  endtask

  // a word offered with the enable low must leave every output alone
  task automatic t_clock_enable();
    @(posedge mclk_in);
    ce_in <= 1'b0;
    instr_in <= {CIDSB_OP_OR_LITERAL_INTO_ACC, 8'hFF};
    instr_valid_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    ce_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    check_all();
    $display("test clock_enable done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_or_literal();
    t_increment();
    do_reset();
    t_or_register();
    t_dec_skip();
    t_inc_skip();
    t_branch();
    t_back_to_back();
    t_clock_enable();
    close_out();
  end

  // the whole run needs about 126 cycles (near 3.2 us), so 50 us is ample margin
  initial begin
    #50000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

endmodule

`default_nettype wire

// ---- verilog/cidsb_core.sv ----
// execution core for six instructions of an 8-bit controller core
// assumes one instruction offered per enabled cycle on instr_valid_in
`timescale 1ns/1ps
`default_nettype none

module cidsb_core
  import cidsb_pkg::*;
(
  input  wire logic                     mclk_in,
  input  wire logic                     nrst_in,
  input  wire logic                     ce_in,
  input  wire logic                     instr_valid_in,
  input  wire logic [CIDSB_IW-1:0]      instr_in,
  input  wire logic [CIDSB_LATCH_W-1:0] pc_high_latch_in,
  input  wire logic [CIDSB_FADDR_W-1:0] peek_addr_in,
  output logic      [CIDSB_DATA_W-1:0]  acc_out,
  output logic                          zero_flag_out,
  output logic      [CIDSB_PC_W-1:0]    pc_out,
  output logic                          no_operation_next_out,
  output logic      [CIDSB_DATA_W-1:0]  peek_data_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cidsb_state_e                state;
  cidsb_state_e                next_state;
  logic [CIDSB_DATA_W-1:0]     file_mem [CIDSB_NREGS];
  logic [CIDSB_DATA_W-1:0]     acc;
  logic                        zero_flag;
  logic [CIDSB_PC_W-1:0]       pc;
  logic                        no_op_next;
  logic [CIDSB_DATA_W-1:0]     peek;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [5:0]                op      = instr_in[CIDSB_OP_HI:CIDSB_OP_LO];
  wire logic [2:0]                br_op   = instr_in[CIDSB_OP_HI:CIDSB_BROP_LO];
  wire logic                      dest    = instr_in[CIDSB_DEST_BIT];
  wire logic [CIDSB_FADDR_W-1:0]  faddr   = instr_in[CIDSB_FADDR_HI:0];
  wire logic [CIDSB_DATA_W-1:0]   lit     = instr_in[CIDSB_LIT_HI:0];
  wire logic [CIDSB_DATA_W-1:0]   fval    = file_mem[faddr];

  wire logic is_dsz   = op == CIDSB_OP_DECREMENT_SKIP_ZERO;
  wire logic is_isz   = op == CIDSB_OP_INCREMENT_SKIP_ZERO;
  wire logic is_inc   = op == CIDSB_OP_INCREMENT_REGISTER;
  wire logic is_or_acc_with_register = op == CIDSB_OP_OR_ACC_WITH_REGISTER;
  wire logic is_or_literal_into_acc = op == CIDSB_OP_OR_LITERAL_INTO_ACC;
  // the branch owns an eighth of the opcode space, so it is matched on three bits only
  wire logic is_branch_absolute  = br_op == CIDSB_OP_BRANCH_ABSOLUTE;
  wire logic is_fop   = is_dsz | is_isz | is_inc | is_or_acc_with_register;

  // an instruction offered during a flush slot is swallowed as a no_operation
  wire logic in_run   = state == CIDSB_ST_RUN;
  wire logic step     = ce_in & instr_valid_in;
  wire logic exec     = step & in_run;
  wire logic flushing = step & ~in_run;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  wire logic [CIDSB_DATA_W-1:0] dec_val = fval - CIDSB_ONE;
  wire logic [CIDSB_DATA_W-1:0] inc_val = fval + CIDSB_ONE;

  wire logic [CIDSB_DATA_W-1:0] next_result =
    is_dsz ? dec_val :
    (is_isz | is_inc) ? inc_val :
    is_or_acc_with_register ? (acc | fval) :
    (acc | lit);

  // zero is judged on the 8-bit result alone; a wrap from FF counts as zero
  wire logic result_zero = next_result == CIDSB_ZERO;

  // destination routing shared by all file-register operations
  wire logic wr_file = exec & is_fop & (dest == CIDSB_DEST_FILE);
  wire logic wr_acc  = exec & ((is_fop & (dest == CIDSB_DEST_ACC)) | is_or_literal_into_acc);

  // the skip forms leave zero alone, only the three plain forms touch it
  wire logic upd_zero = exec & (is_inc | is_or_acc_with_register | is_or_literal_into_acc);

  wire logic skip_now   = exec & (is_dsz | is_isz) & result_zero;
  wire logic branch_now = exec & is_branch_absolute;

  wire logic [CIDSB_PC_W-1:0] branch_target = {
    pc_high_latch_in[CIDSB_LATCH_HI:CIDSB_LATCH_LO],
    instr_in[CIDSB_BRK_HI:0]
  };

  // a skipped word still occupies an address; the slot after a branch does not
  wire logic pc_hold = flushing & (state == CIDSB_ST_BRANCH);

  wire logic [CIDSB_PC_W-1:0] next_pc =
    branch_now ? branch_target :
    (step & ~pc_hold) ? pc + CIDSB_PC_STEP :
    pc;

  wire logic next_zero = upd_zero ? result_zero : zero_flag;

  wire logic [CIDSB_DATA_W-1:0] next_acc = wr_acc ? next_result : acc;

  // skip and branch share one swallow slot; a word offered there is consumed, never queued
  always_comb begin
    next_state = state;
    case (state)
      CIDSB_ST_RUN: begin
        if (skip_now) begin
          next_state = CIDSB_ST_SKIP;
        end else if (branch_now) begin
          next_state = CIDSB_ST_BRANCH;
        end
      end
      CIDSB_ST_SKIP,
      CIDSB_ST_BRANCH: begin
        if (flushing) begin
          next_state = CIDSB_ST_RUN;
        end
      end
      default: next_state = CIDSB_ST_RUN;
    endcase
  end

  wire logic next_no_op = next_state != CIDSB_ST_RUN;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state      <= CIDSB_ST_RUN;
      acc        <= CIDSB_ACC_RST;
      zero_flag  <= CIDSB_Z_RST;
      pc         <= CIDSB_PC_RST;
      no_op_next <= 1'b0;
      peek       <= CIDSB_FILE_RST;
    end else if (ce_in) begin
      state      <= next_state;
      acc        <= next_acc;
      zero_flag  <= next_zero;
      pc         <= next_pc;
      no_op_next <= next_no_op;
      peek       <= file_mem[peek_addr_in];
    end
  end

  // file registers have no read side effects, so a flat array suffices
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < CIDSB_NREGS; i++) begin
        file_mem[i] <= CIDSB_FILE_RST;
      end
    end else if (wr_file) begin
      file_mem[faddr] <= next_result;
    end
  end

  assign acc_out               = acc;
  assign zero_flag_out         = zero_flag;
  assign pc_out                = pc;
  assign no_operation_next_out = no_op_next;
  assign peek_data_out         = peek;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  a_dsz_value_flags: assert property (
    exec && is_dsz && dest == CIDSB_DEST_FILE |=>
      file_mem[$past(faddr)] == 8'($past(fval) - CIDSB_ONE) && zero_flag_out == $past(zero_flag_out))
    else $error("decrement-and-skip wrote a wrong value or moved zero");

  a_dsz_skip: assert property (
    exec && is_dsz |=>
      (state == CIDSB_ST_SKIP) == ($past(fval) == CIDSB_ONE))
    else $error("decrement-and-skip skip decision wrong");

  a_isz_flags_dest: assert property (
    exec && is_isz && dest == CIDSB_DEST_ACC |=>
      acc_out == 8'($past(fval) + CIDSB_ONE) && zero_flag_out == $past(zero_flag_out))
    else $error("increment-and-skip result or flags wrong");

  a_isz_skip_slot: assert property (
    exec && is_isz && fval == 8'hFF ##1 (ce_in && instr_valid_in) |=>
      state == CIDSB_ST_RUN && acc_out == $past(acc_out) && pc_out == 15'($past(pc_out) + CIDSB_PC_STEP))
    else $error("slot after increment-and-skip zero was not a no-operation");

  a_dest_file_keeps_acc: assert property (
    exec && is_fop && dest == CIDSB_DEST_FILE |=> acc_out == $past(acc_out))
    else $error("file destination disturbed the accumulator");

  a_inc_zero: assert property (
    exec && is_inc |=>
      zero_flag_out == ($past(fval) == 8'hFF) && file_mem[$past(faddr)] ==
      ($past(dest) ? 8'($past(fval) + CIDSB_ONE) : $past(fval)))
    else $error("increment result or zero flag wrong");

  a_or_acc_with_register_acc: assert property (
    exec && is_or_acc_with_register && dest == CIDSB_DEST_ACC |=>
      acc_out == ($past(acc_out) | $past(fval)))
    else $error("or-with-register result wrong");

  a_or_literal_into_acc_acc: assert property (
    exec && is_or_literal_into_acc |=>
      acc_out == ($past(acc_out) | $past(lit)) && zero_flag_out == (acc_out == CIDSB_ZERO))
    else $error("or-with-literal result or zero flag wrong");

  a_branch_low: assert property (
    exec && is_branch_absolute |=>
      pc_out[10:0] == $past(instr_in[10:0]) && zero_flag_out == $past(zero_flag_out))
    else $error("branch low address wrong");

  a_branch_high: assert property (
    exec && is_branch_absolute |=> pc_out[14:11] == $past(pc_high_latch_in[6:3]))
    else $error("branch high address not taken from latch bits 6 to 3");

  a_branch_two_cycles: assert property (
    exec && is_branch_absolute ##1 (ce_in && instr_valid_in) |=>
      state == CIDSB_ST_RUN && pc_out == $past(pc_out) && acc_out == $past(acc_out))
    else $error("branch did not take exactly two cycles");

  a_zero_tracks: assert property (
    exec && is_or_acc_with_register |=> zero_flag_out == (($past(acc_out) | $past(fval)) == CIDSB_ZERO))
    else $error("zero flag does not follow the result");

  a_no_op_flag: assert property (
    no_operation_next_out == (state != CIDSB_ST_RUN))
    else $error("no-operation indicator out of step with state");

  a_dsz_dest_acc: assert property (
    exec && is_dsz && dest == CIDSB_DEST_ACC |=>
      acc_out == 8'($past(fval) - CIDSB_ONE) && file_mem[$past(faddr)] == $past(fval))
    else $error("decrement-and-skip to the accumulator went wrong");

  a_dsz_skip_slot: assert property (
    exec && is_dsz && fval == CIDSB_ONE ##1 (ce_in && instr_valid_in) |=>
      state == CIDSB_ST_RUN && acc_out == $past(acc_out) && pc_out == 15'($past(pc_out) + CIDSB_PC_STEP))
    else $error("slot after decrement-and-skip zero was not a no-operation");

  a_flush_keeps_flags: assert property (
    flushing |=> !no_operation_next_out && zero_flag_out == $past(zero_flag_out) &&
      acc_out == $past(acc_out))
    else $error("swallowed word changed state it must not touch");

  a_isz_dest_file: assert property (
    exec && is_isz && dest == CIDSB_DEST_FILE |=>
      file_mem[$past(faddr)] == 8'($past(fval) + CIDSB_ONE) && zero_flag_out == $past(zero_flag_out))
    else $error("increment-and-skip to the register went wrong");

  a_isz_skip: assert property (
    exec && is_isz |=>
      (state == CIDSB_ST_SKIP) == ($past(fval) == 8'hFF))
    else $error("increment-and-skip skip decision wrong");

  a_dest_acc_keeps_file: assert property (
    exec && is_fop && dest == CIDSB_DEST_ACC |=> file_mem[$past(faddr)] == $past(fval))
    else $error("accumulator destination disturbed the register");

  a_inc_dest_acc: assert property (
    exec && is_inc && dest == CIDSB_DEST_ACC |=>
      acc_out == 8'($past(fval) + CIDSB_ONE) && zero_flag_out == (acc_out == CIDSB_ZERO))
    else $error("increment to the accumulator went wrong");

  a_or_acc_with_register_file: assert property (
    exec && is_or_acc_with_register && dest == CIDSB_DEST_FILE |=>
      file_mem[$past(faddr)] == ($past(acc_out) | $past(fval)))
    else $error("or-with-register write-back wrong");

  a_branch_marks_slot: assert property (
    exec && is_branch_absolute |=> no_operation_next_out && state == CIDSB_ST_BRANCH)
    else $error("branch did not mark its second cycle");

  // a low enable must freeze every register, the observation port included
  a_ce_freeze: assert property (
    !ce_in |=> acc_out == $past(acc_out) && pc_out == $past(pc_out) && zero_flag_out == $past(zero_flag_out) &&
      no_operation_next_out == $past(no_operation_next_out) && peek_data_out == $past(peek_data_out))
    else $error("a disabled cycle changed a register");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_dsz_skip: cover property (exec && is_dsz && fval == CIDSB_ONE ##1 flushing);
  c_isz_skip: cover property (exec && is_isz && fval == 8'hFF ##1 flushing);
  c_branch:   cover property (exec && is_branch_absolute ##1 flushing);
  c_or_zero:  cover property (exec && is_or_literal_into_acc && result_zero);
  c_ce_hold:  cover property (!ce_in && instr_valid_in);

endmodule

`default_nettype wire

// ---- verilog/cidsb_pkg.sv ----
// constants for the inc/dec-skip, or and absolute-branch execution block
// assumes a 14-bit instruction word and a 7-bit file register address
package cidsb_pkg;

  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam int unsigned CIDSB_IW        = 14;
  localparam int unsigned CIDSB_OP_HI     = 13;
  localparam int unsigned CIDSB_OP_LO     = 8;
  localparam int unsigned CIDSB_BROP_LO   = 11;
  localparam int unsigned CIDSB_DEST_BIT  = 7;
  localparam int unsigned CIDSB_FADDR_HI  = 6;
  localparam int unsigned CIDSB_LIT_HI    = 7;
  localparam int unsigned CIDSB_BRK_HI    = 10;
  localparam int unsigned CIDSB_LATCH_HI  = 6;
  localparam int unsigned CIDSB_LATCH_LO  = 3;
  localparam int unsigned CIDSB_LATCH_W   = 7;
  localparam int unsigned CIDSB_PC_W      = 15;
  localparam int unsigned CIDSB_FADDR_W   = 7;
  localparam int unsigned CIDSB_DATA_W    = 8;
  localparam int unsigned CIDSB_NREGS     = 128;

  // ----------------------------------------------------------------
  // opcodes (upper six bits, branch uses upper three)
  // ----------------------------------------------------------------
  localparam logic [5:0] CIDSB_OP_DECREMENT_SKIP_ZERO  = 6'h0B;
  localparam logic [5:0] CIDSB_OP_INCREMENT_SKIP_ZERO  = 6'h0F;
  localparam logic [5:0] CIDSB_OP_INCREMENT_REGISTER   = 6'h0A;
  localparam logic [5:0] CIDSB_OP_OR_ACC_WITH_REGISTER = 6'h04;
  localparam logic [5:0] CIDSB_OP_OR_LITERAL_INTO_ACC  = 6'h38;
  localparam logic [2:0] CIDSB_OP_BRANCH_ABSOLUTE      = 3'h5;

  // ----------------------------------------------------------------
  // destination select and reset values
  // ----------------------------------------------------------------
  localparam logic        CIDSB_DEST_ACC  = 1'b0;
  localparam logic        CIDSB_DEST_FILE = 1'b1;
  localparam logic [7:0]  CIDSB_ACC_RST   = 8'h00;
  localparam logic [7:0]  CIDSB_FILE_RST  = 8'h00;
  localparam logic [14:0] CIDSB_PC_RST    = 15'h0000;
  localparam logic        CIDSB_Z_RST     = 1'b0;
  localparam logic [7:0]  CIDSB_ONE       = 8'h01;
  localparam logic [7:0]  CIDSB_ZERO      = 8'h00;
  localparam logic [14:0] CIDSB_PC_STEP   = 15'h0001;

  typedef enum logic [1:0] {
    CIDSB_ST_RUN,
    CIDSB_ST_SKIP,
    CIDSB_ST_BRANCH
  } cidsb_state_e;

endpackage
